//--- pkg/txc_pkg.sv
// transmit framing and coding configuration: register map, field layout,
// coding values and bit-timing counts.
// assumes a 125 MHz system clock and byte-wide register access.
package txc_pkg;

    // ==========================================================
    // register map
    localparam logic [7:0] ADDR_PROBE_CTRL   = 8'h47;
    localparam logic [7:0] ADDR_TX_FRAMING   = 8'h48;
    localparam logic [7:0] ADDR_TX_CODING    = 8'h4a;
    localparam logic [7:0] PROBE_CTRL_MASK   = 8'h8f;  // bits 6..4 reserved
    localparam logic [7:0] TX_FRAMING_MASK   = 8'hab;  // bits 6,4,2 reserved
    localparam logic [7:0] TX_CODING_MASK    = 8'hff;
    localparam logic [7:0] REG_RESET         = 8'h00;

    // ==========================================================
    // field positions
    localparam int FAST_IO_BIT    = 7;
    localparam int PROBE_SEL_LSB  = 0;
    localparam int ORDER_BIT      = 7;
    localparam int PARITY_BIT     = 5;
    localparam int END_LEVEL_BIT  = 3;
    localparam int LEAD_LEVEL_BIT = 1;
    localparam int LEAD_EN_BIT    = 0;
    localparam int CODE_LSB       = 4;
    localparam int SUBC_BIT       = 3;
    localparam int RATE_LSB       = 0;

    // ==========================================================
    // probe pin sources
    localparam logic [3:0] PROBE_LOW     = 4'h2;
    localparam logic [3:0] PROBE_HIGH    = 4'h3;
    localparam logic [3:0] PROBE_TX_ENV  = 4'h4;
    localparam logic [3:0] PROBE_TX_ACT  = 4'h5;
    localparam logic [3:0] PROBE_SCC     = 4'h6;
    localparam logic [3:0] PROBE_RX_ENV  = 4'h7;
    localparam logic [3:0] PROBE_RX_ACT  = 4'h8;
    localparam logic [3:0] PROBE_RX_BIT  = 4'h9;

    // ==========================================================
    // coding values
    localparam logic [3:0] CODE_PLAIN    = 4'h0;
    localparam logic [3:0] CODE_COLLIDER = 4'h1;
    localparam logic [3:0] CODE_RZ1      = 4'h4;
    localparam logic [3:0] CODE_RZ2      = 4'h5;
    localparam logic [3:0] CODE_RZ3      = 4'h6;
    localparam logic [3:0] CODE_RZ3B     = 4'h7;
    localparam logic [3:0] CODE_PPM4     = 4'h8;
    localparam logic [3:0] CODE_PPM256   = 4'h9;
    localparam logic [3:0] CODE_PPM256_Z = 4'ha;
    localparam logic [3:0] CODE_PPM256_L = 4'hb;
    localparam logic [3:0] CODE_PIE      = 4'hc;

    // ==========================================================
    // timing: rates in kHz, counts in system clock cycles (rounded down)
    localparam int CLK_KHZ        = 125000;
    localparam int RATE_26_KHZ    = 26;
    localparam int RATE_53_KHZ    = 53;
    localparam int RATE_106_KHZ   = 106;
    localparam int RATE_212_KHZ   = 212;
    localparam int RATE_424_KHZ   = 424;
    localparam int RATE_848_KHZ   = 848;
    localparam logic [12:0] BIT_CYC_53  = 13'(CLK_KHZ / RATE_53_KHZ);
    localparam logic [12:0] BIT_CYC_106 = 13'(CLK_KHZ / RATE_106_KHZ);
    localparam logic [12:0] BIT_CYC_212 = 13'(CLK_KHZ / RATE_212_KHZ);
    localparam logic [12:0] BIT_CYC_424 = 13'(CLK_KHZ / RATE_424_KHZ);
    localparam logic [12:0] BIT_CYC_848 = 13'(CLK_KHZ / RATE_848_KHZ);
    localparam logic [7:0]  SUBC_HALF_424 = 8'(CLK_KHZ / (2 * RATE_424_KHZ));
    localparam logic [7:0]  SUBC_HALF_848 = 8'(CLK_KHZ / (2 * RATE_848_KHZ));

    typedef enum logic [2:0] {
        TXC_IDLE,
        TXC_LEAD,
        TXC_DATA,
        TXC_PAR,
        TXC_STOP
    } txc_phase_e;

endpackage : txc_pkg

//--- logic/txc_encoder.sv
// transmit bit framing and data coding engine with its configuration
// registers and the probe pin multiplexer.
// assumes a byte-wide synchronous register port and a byte source that
// holds tx_data/tx_valid until tx_taken pulses.
//
// Overview of operation
// - pad speed bit set selects fast I/O switching, clear selects normal speed.
// - probe selector 0h/1h floats the pin, 2h drives low, 3h drives high.
// - selector 4h transmit envelope, 5h transmit active, 6h secure clock channel.
// - selector 7h receive envelope, 8h receive active, 9h received bit.
// - probe control register at 47h: pad speed bit 7, selector low nibble.
// - framing bit 7 set sends each byte high bit first, else low first.
// - framing bit 5 one gives odd parity, zero gives even parity.
// - stop bit level equals framing bit 3.
// - start bit level equals framing bit 1.
// - start bit is sent only when framing bit 0 is one.
// - coding field bits 7..4: 0h plain, 1h collider stream, 2h/3h reserved.
// - codes 4h..6h return-to-zero with pulse at first, second, third position; 7h third.
// - code 8h is 1-of-4 pulse position, each bit pair picks a slot.
// - code 9h is 1-of-256 pulse position over values 0 to 255.
// - code Ah is 1-of-256 where value 00h sends no pulse.
// - code Bh is 1-of-256 where value 00h pulses in the last slot.
// - code Ch is pulse-interval encoding; Dh..Fh reserved.
// - coding bit 3 picks 424 or 848 kHz subcarrier.
// - coding bits 2..0 pick bit rate from 26 to 848 kHz.
`timescale 1ns/100ps
`default_nettype none

module txc_encoder
    import txc_pkg::*;
#(
    parameter logic [12:0] BIT_CYC_26 = 13'(CLK_KHZ / RATE_26_KHZ)
) (
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output var  logic [7:0] reg_rdata,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    input  wire logic       tx_last,
    output var  logic       tx_taken,
    output var  logic       tx_stream,
    output var  logic       tx_active,
    output var  logic       tx_subcarrier,
    input  wire logic       secure_clock_channel,
    input  wire logic       rx_envelope,
    input  wire logic       rx_active,
    input  wire logic       rx_bit,
    output var  logic       probe_output_pin,
    output var  logic       probe_output_pin_oe,
    output var  logic       fast_io_switching
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0]  probe_ctrl;
        logic [7:0]  framing;
        logic [7:0]  coding;
        logic [7:0]  act_framing;
        logic [7:0]  act_coding;
        txc_phase_e  phase;
        logic [7:0]  shreg;
        logic [3:0]  bitn;
        logic        parity;
        logic        last;
        logic [12:0] qcnt;
        logic [12:0] qcyc;
        logic [1:0]  quarter;
        logic [7:0]  slot;
        logic [7:0]  subcnt;
        logic [7:0]  rdata;
        logic        taken;
        logic        stream;
        logic        active;
        logic        subc;
        logic        probe;
        logic        probe_oe;
    } txc_state_s;

    txc_state_s st;
    txc_state_s next_st;

    // ==========================================================
    // line level of one frame bit for bit-level codings
    function automatic logic txc_bit_level(input logic [3:0] code, input logic b, input logic [1:0] q);
        logic lvl;
        lvl = b;
        case (code)
            CODE_RZ1:  lvl = b & (q == 2'd0);
            CODE_RZ2:  lvl = b & (q == 2'd1);
            CODE_RZ3,
            CODE_RZ3B: lvl = b & (q == 2'd2);
            default:   lvl = b;
        endcase
        return lvl;
    endfunction : txc_bit_level

    // bit period for a rate code; reserved codes fall back to 106 kHz
    function automatic logic [12:0] txc_bit_cyc(input logic [2:0] rate);
        logic [12:0] c;
        c = BIT_CYC_106;
        case (rate)
            3'h2:    c = BIT_CYC_26;
            3'h3:    c = BIT_CYC_53;
            3'h4:    c = BIT_CYC_106;
            3'h5:    c = BIT_CYC_212;
            3'h6:    c = BIT_CYC_424;
            3'h7:    c = BIT_CYC_848;
            default: c = BIT_CYC_106;
        endcase
        return c;
    endfunction : txc_bit_cyc

    // ==========================================================
    // next state
    always_comb begin
        logic [3:0] code;
        logic       msb_first;
        logic       ppm;
        logic       pie;
        logic       cur_bit;
        logic       second_bit;
        logic [7:0] target;
        logic       pulse_en;
        logic       qend;
        logic       uend;
        logic       fetch;
        logic       lvl;
        logic [7:0] subhalf;
        code       = st.act_coding[CODE_LSB +: 4];
        msb_first  = st.act_framing[ORDER_BIT];
        ppm        = (code >= CODE_PPM4) && (code <= CODE_PPM256_L);
        pie        = (code == CODE_PIE);
        cur_bit    = msb_first ? st.shreg[7] : st.shreg[0];
        second_bit = msb_first ? st.shreg[6] : st.shreg[1];
        target     = st.shreg;
        pulse_en   = 1'b1;
        fetch      = 1'b0;
        lvl        = 1'b0;
        qend       = st.active && (st.qcnt == st.qcyc - 13'd1);
        uend       = qend && ((st.quarter == 2'd3)
                     || (pie && st.phase == TXC_DATA && !cur_bit && st.quarter == 2'd1));
        subhalf    = st.act_coding[SUBC_BIT] ? SUBC_HALF_848 : SUBC_HALF_424;
        next_st    = st;
        next_st.taken = 1'b0;

        // pulse slot selection for pulse position codes
        if (code == CODE_PPM4) begin
            target = {6'h00, second_bit, cur_bit};
        end else if (code == CODE_PPM256_Z && st.shreg == 8'h00) begin
            pulse_en = 1'b0;
        end else if (code == CODE_PPM256_L && st.shreg == 8'h00) begin
            target = 8'hff;
        end

        // register port; reserved bits masked on write, so they read back as zero
        if (reg_wr) begin
            case (reg_addr)
                ADDR_PROBE_CTRL: next_st.probe_ctrl = reg_wdata & PROBE_CTRL_MASK;
                ADDR_TX_FRAMING: next_st.framing    = reg_wdata & TX_FRAMING_MASK;
                ADDR_TX_CODING:  next_st.coding     = reg_wdata & TX_CODING_MASK;
                default:         next_st.rdata      = st.rdata;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ADDR_PROBE_CTRL: next_st.rdata = st.probe_ctrl;
                ADDR_TX_FRAMING: next_st.rdata = st.framing;
                ADDR_TX_CODING:  next_st.rdata = st.coding;
                default:         next_st.rdata = 8'h00;
            endcase
        end

        // quarter-bit timer; remainder of bit period below 4 cycles is dropped
        if (st.active) begin
            next_st.qcnt = qend ? 13'd0 : st.qcnt + 13'd1;
        end
        if (qend) begin
            next_st.quarter = uend ? 2'd0 : st.quarter + 2'd1;
        end

        // line level of the current quarter
        case (st.phase)
            TXC_LEAD: lvl = txc_bit_level(ppm || pie ? CODE_PLAIN : code,
                                          st.act_framing[LEAD_LEVEL_BIT], st.quarter);
            TXC_PAR:  lvl = txc_bit_level(code, st.parity, st.quarter);
            TXC_STOP: lvl = txc_bit_level(ppm || pie ? CODE_PLAIN : code,
                                          st.act_framing[END_LEVEL_BIT], st.quarter);
            TXC_DATA: begin
                if (ppm) begin
                    lvl = pulse_en && (st.slot == target) && (st.quarter == 2'd1);
                end else if (pie) begin
                    lvl = (st.quarter == (cur_bit ? 2'd3 : 2'd1)); // pulse closes each interval
                end else begin
                    lvl = txc_bit_level(code, cur_bit, st.quarter);
                end
            end
            default: lvl = 1'b0;
        endcase
        next_st.stream = st.active ? lvl : 1'b0;

        // frame sequencing
        case (st.phase)
            TXC_IDLE: begin
                if (tx_valid) begin
                    next_st.act_framing = st.framing;
                    next_st.act_coding  = st.coding;
                    next_st.qcyc        = txc_bit_cyc(st.coding[RATE_LSB +: 3]) >> 2;
                    next_st.qcnt        = 13'd0;
                    next_st.quarter     = 2'd0;
                    next_st.slot        = 8'h00;
                    next_st.subcnt      = 8'h00;
                    next_st.active      = 1'b1;
                    next_st.shreg       = tx_data;
                    next_st.parity      = (^tx_data) ^ st.framing[PARITY_BIT];
                    next_st.last        = tx_last;
                    next_st.bitn        = 4'd0;
                    next_st.taken       = 1'b1;
                    next_st.phase       = st.framing[LEAD_EN_BIT] ? TXC_LEAD : TXC_DATA;
                end
            end
            TXC_LEAD: begin
                if (uend) begin
                    next_st.phase = TXC_DATA;
                end
            end
            TXC_DATA: begin
                if (uend && ppm) begin
                    next_st.slot = st.slot + 8'h01;
                    if (st.slot == ((code == CODE_PPM4) ? 8'h03 : 8'hff)) begin
                        next_st.slot = 8'h00;
                        if (code == CODE_PPM4 && st.bitn != 4'd6) begin
                            next_st.shreg = msb_first ? {st.shreg[5:0], 2'b00} : {2'b00, st.shreg[7:2]};
                            next_st.bitn  = st.bitn + 4'd2;
                        end else begin
                            fetch = 1'b1;
                        end
                    end
                end else if (uend) begin
                    next_st.shreg = msb_first ? {st.shreg[6:0], 1'b0} : {1'b0, st.shreg[7:1]};
                    next_st.bitn  = st.bitn + 4'd1;
                    if (st.bitn == 4'd7) begin
                        if (pie) begin
                            fetch = 1'b1;
                        end else begin
                            next_st.phase = TXC_PAR;
                        end
                    end
                end
            end
            TXC_PAR: begin
                fetch = uend;
            end
            TXC_STOP: begin
                if (uend) begin
                    next_st.phase  = TXC_IDLE;
                    next_st.active = 1'b0;
                    next_st.qcnt   = 13'd0;
                end
            end
            default: next_st.phase = TXC_IDLE;
        endcase

        // next byte, or close the frame on last byte or underrun
        if (fetch) begin
            if (!st.last && tx_valid) begin
                next_st.shreg  = tx_data;
                next_st.parity = (^tx_data) ^ st.act_framing[PARITY_BIT];
                next_st.last   = tx_last;
                next_st.bitn   = 4'd0;
                next_st.taken  = 1'b1;
                next_st.phase  = TXC_DATA;
            end else begin
                next_st.phase = TXC_STOP;
            end
        end

        // subcarrier runs only inside a frame
        if (st.active && next_st.active) begin
            next_st.subcnt = (st.subcnt == subhalf - 8'h01) ? 8'h00 : st.subcnt + 8'h01;
            next_st.subc   = (st.subcnt == subhalf - 8'h01) ? ~st.subc : st.subc;
        end else begin
            next_st.subcnt = 8'h00;
            next_st.subc   = 1'b0;
        end

        // probe pin source; reserved selector codes float the pin
        next_st.probe_oe = 1'b1;
        case (st.probe_ctrl[PROBE_SEL_LSB +: 4])
            PROBE_LOW:    next_st.probe = 1'b0;
            PROBE_HIGH:   next_st.probe = 1'b1;
            PROBE_TX_ENV: next_st.probe = st.stream;
            PROBE_TX_ACT: next_st.probe = st.active;
            PROBE_SCC:    next_st.probe = secure_clock_channel;
            PROBE_RX_ENV: next_st.probe = rx_envelope;
            PROBE_RX_ACT: next_st.probe = rx_active;
            PROBE_RX_BIT: next_st.probe = rx_bit;
            default: begin
                next_st.probe    = 1'b0;
                next_st.probe_oe = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // state register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign reg_rdata           = st.rdata;
    assign tx_taken            = st.taken;
    assign tx_stream           = st.stream;
    assign tx_active           = st.active;
    assign tx_subcarrier       = st.subc;
    assign probe_output_pin    = st.probe;
    assign probe_output_pin_oe = st.probe_oe;
    assign fast_io_switching   = st.probe_ctrl[FAST_IO_BIT];

endmodule : txc_encoder

`default_nettype wire

//--- verification/txc_monitor.sv
// port-level properties of the transmit framing and coding block.
// assumes a bind onto every txc_encoder instance; one clock domain.
`timescale 1ns/100ps
`default_nettype none

module txc_monitor
    import txc_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       tx_taken,
    input wire logic       tx_active,
    input wire logic       tx_subcarrier,
    input wire logic       probe_output_pin,
    input wire logic       probe_output_pin_oe,
    input wire logic       fast_io_switching
);
    default clocking mon_cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // ==========================================================
    // probe control decode helpers
    logic       pw;   // probe write
    logic [3:0] ps;   // new selector
    logic       wd7;  // new pad speed
    assign pw  = reg_wr && reg_addr == ADDR_PROBE_CTRL;
    assign ps  = reg_wdata[3:0];
    assign wd7 = reg_wdata[FAST_IO_BIT];

    // ==========================================================
    // probe pin and pad speed, two cycles after the write edge
    probe_float_a: assert property (pw && (ps < PROBE_LOW || ps > PROBE_RX_BIT) |-> ##2 !probe_output_pin_oe)
        else $error("probe pin driven for a floating selector");
    probe_low_a: assert property (pw && ps == PROBE_LOW |-> ##2 (probe_output_pin_oe && !probe_output_pin))
        else $error("probe pin not driven low");
    probe_high_a: assert property (pw && ps == PROBE_HIGH |-> ##2 (probe_output_pin_oe && probe_output_pin))
        else $error("probe pin not driven high");
    probe_drive_a: assert property (pw && ps inside {[PROBE_TX_ENV:PROBE_RX_BIT]} |-> ##2 probe_output_pin_oe)
        else $error("probe pin floats for a signal selector");
    pad_speed_a: assert property (pw |-> ##2 (fast_io_switching == $past(wd7, 2)))
        else $error("pad speed output differs from written bit");

    // ==========================================================
    // register reads: reserved framing bits and unmapped places read zero
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    rsv_zero_a: assert property (reg_rd && reg_addr == ADDR_TX_FRAMING |=> (reg_rdata & ~TX_FRAMING_MASK) == 8'h00)
        else $error("reserved framing bits read non-zero");
    unmapped_a: assert property (reg_rd && !(reg_addr inside {8'h47, 8'h48, 8'h4a}) |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");

    // ==========================================================
    // frame start and subcarrier quiet between frames
    start_take_a: assert property ($rose(tx_active) |-> tx_taken ##1 !tx_taken)
        else $error("frame start without a single capture pulse");
    subc_idle_a: assert property (!tx_active && !$past(tx_active) |-> !tx_subcarrier)
        else $error("subcarrier running outside a frame");
endmodule : txc_monitor

bind txc_encoder txc_monitor u_txc_monitor (
    .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_taken, .tx_active,
    .tx_subcarrier, .probe_output_pin, .probe_output_pin_oe, .fast_io_switching
);
`default_nettype wire

//--- verification/txc_card_model.sv
// card-side listener: samples the coded line mid-quarter during a frame.
// assumes the coded line lags the frame-active flag by one cycle.
`timescale 1ns/100ps
`default_nettype none

module txc_card_model #(
    parameter int QCYC = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         tx_stream,
    input  wire logic         tx_active,
    input  wire logic         tx_subcarrier,
    output var  logic [127:0] lv,
    output var  int           quarters,
    output var  int           pulses,
    output var  int           first_hi,
    output var  int           half
);
    int   ph;  // cycles since frame start
    int   sc;  // cycles since last subcarrier edge
    int   tg;  // subcarrier edges this frame
    logic sp;  // previous subcarrier level

    // mid-quarter sampling stays clear of level changes; half is the
    // span from frame start to the first subcarrier edge
    always @(posedge sys_clk) begin
        sp <= tx_subcarrier;
        ph <= tx_active ? ph + 1 : 0;
        sc <= (tx_subcarrier != sp) ? 1 : sc + 1;
        if (tx_active && ph == 0) begin
            {quarters, pulses, first_hi, tg, sc} <= {32'd0, 32'd0, -32'sd1, 32'd0, 32'd1};
        end else if (tx_active) begin
            if (tx_subcarrier != sp) begin
                tg <= tg + 1;
                if (tg == 0) half <= sc;
            end
            if ((ph - 1) % QCYC == QCYC / 2) begin
                lv       <= {lv[126:0], tx_stream};
                quarters <= quarters + 1;
                pulses   <= pulses + int'(tx_stream);
                if (tx_stream && first_hi < 0) first_hi <= quarters;
            end
        end
    end
endmodule : txc_card_model
`default_nettype wire

//--- verification/tb_txc_encoder.sv
// self-checking bench for the transmit framing and coding block.
// assumes txc_card_model listens on the coded line; 26 kHz bit time shortened.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_txc_encoder
    import txc_pkg::*;
;
    localparam logic [12:0] CYC26 = 13'd32;         // short bit time keeps 1-of-256 frames cheap
    localparam int          Q     = int'(CYC26) / 4;
    logic         sys_clk, nrst, reg_wr, reg_rd, tx_valid, tx_last, scc, rx_env, rx_act, rx_bit, f, sb;
    logic [7:0]   reg_addr, reg_wdata, tx_data, reg_rdata, fr, d;
    logic         tx_taken, tx_stream, tx_active, tx_subc, pin, pin_oe, fast_io;
    logic [9:2]   pv;
    logic [127:0] lv, ev;
    int           quarters, pulses, first_hi, half, en, p;
    int           mismatches = 0;
    int           compares = 0;
    logic [7:0]   ra [4] = '{ADDR_PROBE_CTRL, ADDR_TX_FRAMING, ADDR_TX_CODING, 8'h49};
    logic [7:0]   rm [4] = '{PROBE_CTRL_MASK, TX_FRAMING_MASK, TX_CODING_MASK, 8'h00};
    logic [3:0]   pc [4] = '{CODE_PPM256_Z, CODE_PPM256_L, CODE_PPM256, CODE_PPM256_L};

    always #4 sys_clk = ~sys_clk;

    txc_encoder #(.BIT_CYC_26(CYC26)) u_txc_encoder (
        .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .tx_data, .tx_valid, .tx_last,
        .tx_taken, .tx_stream, .tx_active, .tx_subcarrier(tx_subc), .secure_clock_channel(scc),
        .rx_envelope(rx_env), .rx_active(rx_act), .rx_bit, .probe_output_pin(pin),
        .probe_output_pin_oe(pin_oe), .fast_io_switching(fast_io)
    );
    txc_card_model #(.QCYC(Q)) u_txc_card_model (
        .sys_clk, .tx_stream, .tx_active, .tx_subcarrier(tx_subc), .lv, .quarters, .pulses, .first_hi, .half
    );

    // ==========================================================
    // register port and byte source drivers, all off the falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        @(negedge sys_clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge sys_clk);
        reg_rd = 1'b0;
        @(negedge sys_clk);
        `CHK(reg_rdata, e)
    endtask : rdc
    // config is rewritten mid-frame on purpose: the frame must keep its copy
    task automatic send(input logic [3:0] c, input logic [7:0] fv, input logic [7:0] dv);
        int k;
        k = 0;
        sb = 1'($urandom);
        wr(ADDR_TX_CODING, {c, sb, 3'h2});
        wr(ADDR_TX_FRAMING, fv);
        @(negedge sys_clk);
        {tx_data, tx_valid} = {dv, 1'b1};
        do @(negedge sys_clk); while (tx_taken !== 1'b1 && ++k < 50);
        `CHK(tx_taken, 1'b1)
        {tx_data, tx_valid} = {~dv, 1'b0};
        wr(ADDR_TX_FRAMING, ~fv);
        wr(ADDR_TX_CODING, 8'($urandom));
        do @(negedge sys_clk); while (tx_active !== 1'b0 && ++k < 20000);
        `CHK(tx_active, 1'b0)
        repeat (2) @(negedge sys_clk);
        `CHK(half, sb ? int'(SUBC_HALF_848) : int'(SUBC_HALF_424))
    endtask : send

    // ==========================================================
    // expected quarter levels of one frame, newest in bit 0
    function automatic void addq(input logic b);
        ev = {ev[126:0], b};
        en++;
    endfunction : addq
    function automatic void unit(input logic b, input logic [3:0] c);
        for (int q = 0; q < 4; q++) addq(c inside {[4'h4:4'h7]} ? b && q == (c == CODE_RZ1 ? 0 : c == CODE_RZ2 ? 1 : 2) : b);
    endfunction : unit
    function automatic void expect_frame(input logic [3:0] c, input logic [7:0] fv, input logic [7:0] dv);
        logic       pp;
        logic [7:0] b;
        {ev, en, pp} = {128'h0, 32'd0, c == CODE_PPM4 || c == CODE_PIE};
        for (int i = 0; i < 8; i++) b[i] = fv[ORDER_BIT] ? dv[7 - i] : dv[i];
        if (fv[LEAD_EN_BIT]) unit(fv[LEAD_LEVEL_BIT], pp ? CODE_PLAIN : c);
        if (c == CODE_PPM4) begin
            for (int s = 0; s < 16; s++) for (int q = 0; q < 4; q++) addq(q == 1 && s % 4 == {b[s / 4 * 2 + 1], b[s / 4 * 2]});
        end else if (c == CODE_PIE) begin
            for (int i = 0; i < 8; i++) for (int q = 0; q < (b[i] ? 4 : 2); q++) addq(q == (b[i] ? 3 : 1));
        end else begin
            for (int i = 0; i < 8; i++) unit(b[i], c);
            unit(^dv ^ fv[PARITY_BIT], c);
        end
        unit(fv[END_LEVEL_BIT], pp ? CODE_PLAIN : c);
    endfunction : expect_frame

    // ==========================================================
    // main sequence
    initial begin
        {sys_clk, nrst, reg_wr, reg_rd, tx_valid, tx_last, scc, rx_env, rx_act, rx_bit} = 10'h010;
        {reg_addr, reg_wdata, tx_data} = 24'h0;
        void'($urandom(39));
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        nrst = 1'b1;
        for (int i = 0; i < 4; i++) rdc(ra[i], REG_RESET);
        for (int i = 0; i < 4; i++) begin
            wr(ra[i], 8'hff);
            rdc(ra[i], rm[i]);
        end
        for (int s = 0; s < 16; s++) begin
            f = 1'($urandom);
            wr(ADDR_PROBE_CTRL, {f, 3'($urandom), 4'(s)});
            {scc, rx_env, rx_act, rx_bit} = 4'($urandom);
            pv = {rx_bit, rx_act, rx_env, scc, 4'b0010};
            repeat (4) @(negedge sys_clk);
            `CHK(fast_io, f)
            `CHK(pin_oe, 1'(s inside {[2:9]}))
            if (s inside {[2:9]}) `CHK(pin, pv[s])
        end
        for (int c = 0; c < 16; c++) begin
            if (c inside {[9:11]}) continue;
            for (int n = 0; n < 2; n++) begin
                fr = 8'($urandom);
                d = n ? 8'($urandom) : 8'hff;
                expect_frame(4'(c), fr, d);
                send(4'(c), fr, d);
                `CHK(quarters, en)
                `CHK((lv ^ ev) & ((128'h1 << en) - 128'h1), 128'h0)
            end
        end
        for (int i = 0; i < 4; i++) begin
            d = (i < 2) ? 8'h00 : 8'($urandom_range(255, 1));
            p = (pc[i] == CODE_PPM256_L && d == 8'h00) ? 255 : int'(d);
            send(pc[i], 8'h00, d);
            `CHK(quarters, 1028)
            `CHK(pulses, (pc[i] == CODE_PPM256_Z && d == 8'h00) ? 0 : 1)
            `CHK(first_hi, (pc[i] == CODE_PPM256_Z && d == 8'h00) ? -1 : 4 * p + 1)
        end
        print_verdict();
    end

    // a hang costs a mismatch; the span is twice the expected run
    initial begin
        #720000;
        mismatches++;
        print_verdict();
    end

    task automatic print_verdict;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
endmodule : tb_txc_encoder
`default_nettype wire
